/* File: tipc_pkg.sv */
// Constants for the group power control and tone-disable interrupt block.
// Assumes a host register port of 8-bit data with a byte address.
package tipc_pkg;
  localparam int unsigned NGROUP          = 4;
  localparam int unsigned NCHAN           = 8;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam logic [7:0]  MAIN_CTRL_BASE  = 8'h00;
  localparam logic [7:0]  FIFO_ADDR       = 8'h08;
  localparam logic [7:0]  CHAN_BASE       = 8'h40;
  localparam logic [7:0]  CTRL1_OFS       = 8'h00;
  localparam logic [7:0]  STATUS_OFS      = 8'h02;
  localparam logic [7:0]  CANCELLER_B_OFS = 8'h20;
  localparam logic [7:0]  CTRL1_A_RESET   = 8'h00;
  localparam logic [7:0]  CTRL1_B_RESET   = 8'h02;
  localparam logic [7:0]  MAIN_RESET      = 8'h00;
  localparam int unsigned GROUP_POWER_UP_BIT        = 0;
  localparam int unsigned A_MASK_BIT      = 3;
  localparam int unsigned B_MASK_BIT      = 4;
  localparam int unsigned GLOBAL_MASK_BIT = 5;
  localparam int unsigned INIT_BIT        = 7;
  localparam int unsigned NOISE_OFF_BIT   = 6;
  localparam int unsigned TONE_FLAG_BIT   = 0;
  localparam int unsigned CLOCK_HZ        = 20000000;
  localparam int unsigned FRAME_NS        = 125000;
  localparam int unsigned FRAME_CYCLES    = FRAME_NS / (1000000000 / CLOCK_HZ);
  localparam int unsigned PASS_FRAMES     = 2;
  localparam int unsigned INIT_FRAMES     = 2;
endpackage

/* File: tipc_frame_tick.sv */
// Frame-rate enable divider.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module tipc_frame_tick (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  logic [12:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 13'h0000;
    end else if (cnt_q == 13'(tipc_pkg::FRAME_CYCLES - 1)) begin
      cnt_q <= 13'h0000;
    end else begin
      cnt_q <= cnt_q + 13'h0001;
    end
  end
  assign tick = (cnt_q == 13'(tipc_pkg::FRAME_CYCLES - 1));
endmodule

/* File: tipc_top.sv */
// Group power control and tone-disable interrupt FIFO.
// Assumes a synchronous host strobe port on CLOCK;
// the tone pins and PCM bytes arrive from outside the domain and are synchronised.
`timescale 1ns/1ps
module tipc_top (
  input  wire logic                        CLOCK,
  input  wire logic                        RESET,
  input  wire logic [7:0]                  ADDR,
  input  wire logic [7:0]                  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [7:0]                  RDATA,
  output logic                             IRQ_N,
  input  wire logic [tipc_pkg::NCHAN-1:0]  TONE_DET,
  input  wire logic [tipc_pkg::NCHAN*8-1:0] RIN,
  input  wire logic [tipc_pkg::NCHAN*8-1:0] SIN,
  output logic      [tipc_pkg::NCHAN*8-1:0] ROUT,
  output logic      [tipc_pkg::NCHAN*8-1:0] SOUT,
  output logic      [tipc_pkg::NGROUP-1:0] GROUP_ACTIVE,
  output logic      [tipc_pkg::NCHAN-1:0]  NOISE_ENABLE,
  output logic      [tipc_pkg::NCHAN-1:0]  CLEAR_COEFF
);
  localparam int NC = tipc_pkg::NCHAN;
  localparam int NG = tipc_pkg::NGROUP;
  localparam int FD = tipc_pkg::FIFO_DEPTH;

  logic       frame_tick;
  logic [7:0] main_q [NG];
  logic [7:0] ctrl1_q [NC];
  logic [1:0] init_cnt_q [NG];
  logic [NC-1:0] tone_s1_q, tone_s2_q, tone_s3_q, tone_q;
  logic [2:0] fifo_q [FD];
  logic [3:0] rd_ptr_q, wr_ptr_q;
  logic [4:0] count_q;
  logic       irq_q;
  logic       irq_wait_q;
  logic [NC*8-1:0] rin_d1_q, rin_d2_q, sin_d1_q, sin_d2_q;
  logic [NC-1:0] ev_elig;
  logic          ev_valid;
  logic [2:0]    ev_chan;

  tipc_frame_tick u_tick (
    .clk  (CLOCK),
    .rst  (RESET),
    .tick (frame_tick)
  );

  // Channel register address decode: returns channel or -1
  function automatic int chan_of(input logic [7:0] a, input logic [7:0] ofs);
    int g;
    chan_of = -1;
    if (a >= tipc_pkg::CHAN_BASE) begin
      g = int'(a - tipc_pkg::CHAN_BASE) >> 6;
      if (g < NG && ((a - tipc_pkg::CHAN_BASE) & 8'h1f) == ofs)
        chan_of = 2 * g + (((a - tipc_pkg::CHAN_BASE) & tipc_pkg::CANCELLER_B_OFS) != 0);
    end
  endfunction

  wire fifo_rd = RD && (ADDR == tipc_pkg::FIFO_ADDR);

  // Main control registers; power-up transition starts initialization
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      for (int g = 0; g < NG; g++) main_q[g] <= tipc_pkg::MAIN_RESET;
    end else if (WR && ADDR < tipc_pkg::MAIN_CTRL_BASE + 8'(NG)) begin
      main_q[ADDR[1:0]] <= WDATA;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      for (int g = 0; g < NG; g++) init_cnt_q[g] <= 2'h0;
    end else begin
      for (int g = 0; g < NG; g++) begin
        if (WR && ADDR == 8'(g) && WDATA[tipc_pkg::GROUP_POWER_UP_BIT] &&
            !main_q[g][tipc_pkg::GROUP_POWER_UP_BIT]) begin
          init_cnt_q[g] <= 2'(tipc_pkg::INIT_FRAMES);
        end else if (frame_tick && init_cnt_q[g] != 2'h0) begin
          init_cnt_q[g] <= init_cnt_q[g] - 2'h1;
        end
      end
    end
  end

  // Per-channel control one; init bit presets the channel's own register
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      for (int c = 0; c < NC; c++)
        ctrl1_q[c] <= c[0] ? tipc_pkg::CTRL1_B_RESET : tipc_pkg::CTRL1_A_RESET;
    end else begin
      for (int c = 0; c < NC; c++) begin
        if (ctrl1_q[c][tipc_pkg::INIT_BIT] ||
            (WR && ADDR == 8'(c >> 1) && WDATA[tipc_pkg::GROUP_POWER_UP_BIT] &&
             !main_q[c >> 1][tipc_pkg::GROUP_POWER_UP_BIT])) begin
          ctrl1_q[c] <= c[0] ? tipc_pkg::CTRL1_B_RESET : tipc_pkg::CTRL1_A_RESET;
        end else if (WR && chan_of(ADDR, tipc_pkg::CTRL1_OFS) == c &&
                     init_cnt_q[c >> 1] == 2'h0) begin
          ctrl1_q[c] <= WDATA;
        end
      end
    end
  end

  // Three-stage sync on tone detector levels; change counts when stages 2 and 3 agree
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      tone_s1_q <= '0;
      tone_s2_q <= '0;
      tone_s3_q <= '0;
      tone_q    <= '0;
    end else begin
      tone_s1_q <= TONE_DET;
      tone_s2_q <= tone_s1_q;
      tone_s3_q <= tone_s2_q;
      // A change that lost arbitration keeps its old level so it is retaken next cycle
      for (int c = 0; c < NC; c++)
        if (tone_s2_q[c] == tone_s3_q[c] && !(ev_elig[c] && ev_chan != 3'(c)))
          tone_q[c] <= tone_s3_q[c];
    end
  end

  // Event per edge; lowest channel wins when several change together,
  // the others keep their old filtered level and are retaken next cycle.
  always_comb begin
    ev_elig  = '0;
    ev_valid = 1'b0;
    ev_chan  = 3'h0;
    for (int c = NC - 1; c >= 0; c--) begin
      if (tone_s2_q[c] == tone_s3_q[c] && tone_s3_q[c] != tone_q[c] &&
          main_q[c >> 1][tipc_pkg::GROUP_POWER_UP_BIT] &&
          !main_q[c >> 1][c[0] ? tipc_pkg::B_MASK_BIT : tipc_pkg::A_MASK_BIT]) begin
        ev_elig[c] = 1'b1;
        ev_valid = 1'b1;
        ev_chan  = 3'(c);
      end
    end
  end

  wire fifo_push = ev_valid && count_q != 5'(FD);
  wire fifo_pop  = fifo_rd && count_q != 5'h00;

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q  <= 5'h00;
      for (int i = 0; i < FD; i++) fifo_q[i] <= 3'h0;
    end else begin
      if (fifo_push) begin
        fifo_q[wr_ptr_q] <= ev_chan;
        wr_ptr_q         <= wr_ptr_q + 4'h1;
      end
      if (fifo_pop) rd_ptr_q <= rd_ptr_q + 4'h1;
      count_q <= count_q + 5'(fifo_push) - 5'(fifo_pop);
    end
  end

  // Interrupt: low while entries remain and group 0's global mask bit is clear; a FIFO read forces two high cycles
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      irq_q      <= 1'b0;
      irq_wait_q <= 1'b0;
    end else begin
      irq_wait_q <= fifo_rd;
      if (fifo_rd || irq_wait_q) begin
        irq_q <= 1'b0;
      end else begin
        irq_q <= count_q != 5'h00 && !main_q[0][tipc_pkg::GLOBAL_MASK_BIT];
      end
    end
  end
  assign IRQ_N = !irq_q;

  // Host read data
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= 8'h00;
      if (ADDR < tipc_pkg::MAIN_CTRL_BASE + 8'(NG)) RDATA <= main_q[ADDR[1:0]];
      else if (fifo_rd) RDATA <= (count_q != 5'h00) ? {5'h00, fifo_q[rd_ptr_q]} : 8'h00;
      else begin
        for (int c = 0; c < NC; c++) begin
          if (chan_of(ADDR, tipc_pkg::CTRL1_OFS) == c) RDATA <= ctrl1_q[c];
          if (chan_of(ADDR, tipc_pkg::STATUS_OFS) == c)
            RDATA <= 8'(tone_q[c]) << tipc_pkg::TONE_FLAG_BIT;
        end
      end
    end
  end

  // Two-frame PCM pass-through for powered-down groups
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      rin_d1_q <= '0;
      rin_d2_q <= '0;
      sin_d1_q <= '0;
      sin_d2_q <= '0;
      ROUT     <= '0;
      SOUT     <= '0;
    end else if (frame_tick) begin
      rin_d1_q <= RIN;
      rin_d2_q <= rin_d1_q;
      sin_d1_q <= SIN;
      sin_d2_q <= sin_d1_q;
      for (int c = 0; c < NC; c++) begin
        if (!main_q[c >> 1][tipc_pkg::GROUP_POWER_UP_BIT]) begin
          ROUT[c*8 +: 8] <= rin_d2_q[c*8 +: 8];
          SOUT[c*8 +: 8] <= sin_d2_q[c*8 +: 8];
        end else begin
          ROUT[c*8 +: 8] <= 8'h00;
          SOUT[c*8 +: 8] <= 8'h00;
        end
      end
    end
  end

  always_comb begin
    for (int g = 0; g < NG; g++)
      GROUP_ACTIVE[g] = main_q[g][tipc_pkg::GROUP_POWER_UP_BIT] && init_cnt_q[g] == 2'h0;
    for (int c = 0; c < NC; c++) begin
      NOISE_ENABLE[c] = !ctrl1_q[c][tipc_pkg::NOISE_OFF_BIT];
      CLEAR_COEFF[c]  = init_cnt_q[c >> 1] != 2'h0;
    end
  end
endmodule

/* File: tipc_top_checker.sv */
// Port assertions for the tone interrupt block.
// Assumes a bind onto tipc_top and one clock domain.
`timescale 1ns/1ps
module tipc_top_checker (
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic [7:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  input wire logic        IRQ_N,
  input wire logic [63:0] ROUT,
  input wire logic [63:0] SOUT,
  input wire logic [3:0]  GROUP_ACTIVE,
  input wire logic [7:0]  NOISE_ENABLE,
  input wire logic [7:0]  CLEAR_COEFF
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  wire logic fifo_rd = RD && ADDR == 8'h08;
  property p_rd_high; fifo_rd |=> IRQ_N [*2]; endproperty
  a_rd_high: assert property (p_rd_high) else $error("irq low after read");
  // A mask write may lift the line, so only FIFO reads and writes are excused
  property p_low_held; !IRQ_N && !WR && !fifo_rd |=> !IRQ_N; endproperty
  a_low_held: assert property (p_low_held) else $error("irq left early");
  property p_chan; fifo_rd |=> RDATA < 8'h08; endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
  property p_down; WR && ADDR == 8'h00 && !WDATA[0] |=> !GROUP_ACTIVE[0]; endproperty
  a_down: assert property (p_down) else $error("group still up");
  property p_init; $rose(GROUP_ACTIVE[0]) |-> $past(CLEAR_COEFF[0]); endproperty
  a_init: assert property (p_init) else $error("up without init");
  property p_preset; CLEAR_COEFF[0] |-> !GROUP_ACTIVE[0] && NOISE_ENABLE[0]; endproperty
  a_preset: assert property (p_preset) else $error("no preset");
  property p_noise;
    WR && ADDR == 8'h40 && !WDATA[7] && !CLEAR_COEFF[0] |=> NOISE_ENABLE[0] == !$past(WDATA[6]);
  endproperty
  a_noise: assert property (p_noise) else $error("noise enable wrong");
  property p_pass; GROUP_ACTIVE[0] [*2] |-> ROUT[7:0] == 8'h00 && SOUT[7:0] == 8'h00; endproperty
  a_pass: assert property (p_pass) else $error("bypass while up");
endmodule
bind tipc_top tipc_top_checker tipc_top_checker_inst (.CLOCK, .RESET, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .IRQ_N, .ROUT, .SOUT, .GROUP_ACTIVE, .NOISE_ENABLE, .CLEAR_COEFF);

/* File: tipc_host.sv */
// Host processor model: byte register cycles and interrupt service.
// Assumes requests launched at the falling edge and taken at the rising one.
`timescale 1ns/1ps
module tipc_host (
  input  wire logic       CLOCK,
  input  wire logic [7:0] RDATA,
  output logic      [7:0] ADDR,
  output logic      [7:0] WDATA,
  output logic            WR,
  output logic            RD
);
  initial begin
    ADDR = 8'h00;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
  end
  // Idle bus shows inverted values so stale data cannot pass for fresh
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    ADDR = a;
    WDATA = d;
    WR = 1'b1;
    @(negedge CLOCK);
    WR = 1'b0;
    ADDR = ~a;
    WDATA = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLOCK);
    ADDR = a;
    RD = 1'b1;
    @(negedge CLOCK);
    RD = 1'b0;
    ADDR = ~a;
    d = RDATA;
  endtask
  task automatic service(output logic [7:0] ch, output logic [7:0] st);
    rd(8'h08, ch);
    rd(8'h42 + {ch[2:1], 6'h00} + {ch[0], 5'h00}, st);
  endtask
endmodule

/* File: tipc_top_tb.sv */
// Bench for tipc_top driven through the host model.
// Assumes the checker is bound onto the design.
`timescale 1ns/1ps
module tipc_top_tb;
  logic        CLOCK = 1'b0;
  logic        RESET = 1'b1;
  logic [7:0]  ADDR, WDATA, RDATA, NOISE_ENABLE, CLEAR_COEFF, d, s;
  logic [7:0]  TONE_DET = 8'h00;
  logic        WR, RD, IRQ_N;
  logic [63:0] RIN = {8{8'h5a}}, SIN = {8{8'hc3}}, ROUT, SOUT;
  logic [3:0]  GROUP_ACTIVE;
  int          miscompares = 0, num_checks = 0;
  always #25 CLOCK = ~CLOCK;
  tipc_top tipc_top_inst (.CLOCK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ_N, .TONE_DET,
    .RIN, .SIN, .ROUT, .SOUT, .GROUP_ACTIVE, .NOISE_ENABLE, .CLEAR_COEFF);
  tipc_host tipc_host_inst (.CLOCK, .RDATA, .ADDR, .WDATA, .WR, .RD);
  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_sig(input int w, input logic v, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge CLOCK);
      if ((w == 0 ? IRQ_N : GROUP_ACTIVE[0]) === v) return;
    end
    miscompares++;
    $display("MISMATCH wait %0d expected %b seen timeout", w, v);
    report_and_stop();
  endtask
  task automatic t_reset();
    tipc_host_inst.rd(8'h40, d);
    chk("ctrl1 a", 8'h00, d);
    tipc_host_inst.rd(8'h60, d);
    chk("ctrl1 b", 8'h02, d);
  endtask
  task automatic t_power();
    tipc_host_inst.wr(8'h00, 8'h01);
    wait_sig(1, 1'b1, 6000);
    tipc_host_inst.wr(8'h00, 8'h00);
    chk("active", 8'h00, {4'h0, GROUP_ACTIVE});
    repeat (7500) @(negedge CLOCK);
    chk("rout", 8'h5a, ROUT[7:0]);
    chk("sout", 8'hc3, SOUT[7:0]);
  endtask
  task automatic t_irq();
    tipc_host_inst.wr(8'h00, 8'h01);
    wait_sig(1, 1'b1, 6000);
    TONE_DET = 8'h03;
    wait_sig(0, 1'b0, 20);
    tipc_host_inst.rd(8'h08, d);
    chk("irq", 8'h01, {7'h00, IRQ_N});
    chk("first", 8'h00, d);
    tipc_host_inst.rd(8'h42, s);
    chk("status", 8'h01, s);
    wait_sig(0, 1'b0, 20);
    tipc_host_inst.service(d, s);
    chk("second", 8'h01, d);
    chk("status", 8'h01, s);
    TONE_DET = 8'h02;
    wait_sig(0, 1'b0, 20);
    tipc_host_inst.service(d, s);
    chk("release", 8'h00, d);
    chk("status", 8'h00, s);
  endtask
  task automatic t_mask();
    tipc_host_inst.wr(8'h00, 8'h11);
    TONE_DET = 8'h00;
    repeat (10) @(negedge CLOCK);
    chk("irq", 8'h01, {7'h00, IRQ_N});
    tipc_host_inst.rd(8'h08, d);
    chk("empty", 8'h00, d);
    tipc_host_inst.wr(8'h00, 8'h21);
    TONE_DET = 8'h02;
    repeat (10) @(negedge CLOCK);
    chk("irq", 8'h01, {7'h00, IRQ_N});
    tipc_host_inst.rd(8'h08, d);
    chk("kept", 8'h01, d);
  endtask
  task automatic t_ctrl();
    tipc_host_inst.wr(8'h40, 8'h40);
    chk("noise", 8'h00, {7'h00, NOISE_ENABLE[0]});
    tipc_host_inst.wr(8'h40, 8'h80);
    tipc_host_inst.rd(8'h40, d);
    chk("preset", 8'h00, d);
    chk("noise", 8'h01, {7'h00, NOISE_ENABLE[0]});
    tipc_host_inst.wr(8'h40, 8'h08);
    repeat (2500) @(negedge CLOCK);
    tipc_host_inst.wr(8'h40, 8'h00);
    tipc_host_inst.rd(8'h40, d);
    chk("adapt", 8'h00, d);
  endtask
  initial begin
    repeat (3) @(negedge CLOCK);
    RESET = 1'b0;
    t_reset();
    t_power();
    t_irq();
    t_mask();
    t_ctrl();
    report_and_stop();
  end
endmodule
